/* File: hdl/priority_interrupt_vectoring_unit.sv */
// Interrupt arbitration, vectoring and in-service tracking with an APB register port
`timescale 1ns/1ps
`include "irq_vec_defines.svh"
module priority_interrupt_vectoring_unit #(
    parameter logic [15:0] VEC0 = 16'h0003,
    parameter logic [15:0] VEC1 = 16'h000B,
    parameter logic [15:0] VEC2 = 16'h0013,
    parameter logic [15:0] VEC3 = 16'h001B,
    parameter logic [15:0] VEC4 = 16'h0023,
    parameter logic [15:0] VEC5 = 16'h002B,
    parameter logic [15:0] VEC6 = 16'h0033,
    parameter logic [15:0] VEC7 = 16'h003B
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_request_pin_a,
    input wire logic ext_request_pin_b,
    input wire logic timer_zero_overflow_flag,
    input wire logic timer_one_overflow_flag,
    input wire logic [3:0] other_req,
    input wire logic last_cycle,
    input wire logic ctrl_write,
    input wire logic reti_exec,
    input wire logic ret_exec,
    output logic vector_call,
    output irq_vec_pkg::vector_type vector_addr,
    output logic [7:0] clear_src,
    output logic [3:0] in_service
);
    import irq_vec_pkg::*;

    logic [3:0] mc_cnt_ff;
    logic mc_tick_ff;
    logic [1:0] pin_a_sync_ff, pin_b_sync_ff;
    logic pin_a_prev_ff, pin_b_prev_ff;
    logic edge_flag_a_ff, edge_flag_b_ff;
    logic [7:0] irq_enable_reg, priority_low_reg, priority_high_reg, extended_irq_control_reg;
    logic [1:0] ext_mode_ff;
    logic [3:0] in_service_ff;
    logic vector_call_ff;
    vector_type vector_addr_ff;
    logic [7:0] clear_src_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [7:0] ext_request_flag;
    logic [7:0] pend;
    logic [7:0] prio_low_all, prio_high_all;
    logic found;
    idx_type win_idx;
    level_type win_level;

    wire mc_end = (mc_cnt_ff == `MC_LAST);
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite && pready_ff;
    wire fall_a = pin_a_prev_ff && !pin_a_sync_ff[1];
    wire fall_b = pin_b_prev_ff && !pin_b_sync_ff[1];

    // Machine-cycle divider: one tick per twelve clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cnt_ff <= 4'h0;
            mc_tick_ff <= 1'b0;
        end else begin
            mc_cnt_ff <= mc_end ? 4'h0 : mc_cnt_ff + 4'h1;
            mc_tick_ff <= mc_end;
        end
    end

    // Pins pass two flip-flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_sync_ff <= 2'h3;
            pin_b_sync_ff <= 2'h3;
        end else begin
            pin_a_sync_ff <= {pin_a_sync_ff[0], ext_request_pin_a};
            pin_b_sync_ff <= {pin_b_sync_ff[0], ext_request_pin_b};
        end
    end

    // Pins are sampled once per machine cycle; falling edge sets the edge flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_prev_ff <= 1'b1;
            pin_b_prev_ff <= 1'b1;
            edge_flag_a_ff <= 1'b0;
            edge_flag_b_ff <= 1'b0;
        end else begin
            if (mc_tick_ff) begin
                pin_a_prev_ff <= pin_a_sync_ff[1];
                pin_b_prev_ff <= pin_b_sync_ff[1];
            end
            // edge flag cleared on vectoring, new edge wins
            edge_flag_a_ff <= (mc_tick_ff && fall_a)
                || (edge_flag_a_ff && !clear_src_ff[`SRC_EXT_A]);
            edge_flag_b_ff <= (mc_tick_ff && fall_b)
                || (edge_flag_b_ff && !clear_src_ff[`SRC_EXT_B]);
        end
    end

    // level flag simply follows the inverted pin
    assign ext_request_flag[`SRC_EXT_A] = ext_mode_ff[0] ? edge_flag_a_ff : !pin_a_sync_ff[1];
    assign ext_request_flag[`SRC_EXT_B] = ext_mode_ff[1] ? edge_flag_b_ff : !pin_b_sync_ff[1];
    assign ext_request_flag[`SRC_TMR0] = timer_zero_overflow_flag;
    assign ext_request_flag[`SRC_TMR1] = timer_one_overflow_flag;
    assign ext_request_flag[7:4] = other_req;

    assign pend = ext_request_flag & irq_enable_reg & {8{irq_enable_reg[`GLOBAL_EN_BIT]}}
        & 8'h7F;

    // level formed from high and low priority bits
    assign prio_low_all = {priority_low_reg[7:6],
        priority_low_reg[5] | extended_irq_control_reg[`XCTRL_PRIO_B_BIT],
        priority_low_reg[4] | extended_irq_control_reg[`XCTRL_PRIO_A_BIT], priority_low_reg[3:0]};
    assign prio_high_all = priority_high_reg;

    // resolve winner from this cycle's flags
    level_resolver u_resolver (
        .pend(pend),
        .prio_low(prio_low_all),
        .prio_high(prio_high_all),
        .found(found),
        .win_idx(win_idx),
        .win_level(win_level)
    );

    function automatic logic blocked_by(input logic [3:0] svc, input level_type lvl);
        blocked_by = |(svc >> lvl);
    endfunction

    function automatic vector_type vec_of(input idx_type i);
        case (i)
            4'h0: vec_of = VEC0;
            4'h1: vec_of = VEC1;
            4'h2: vec_of = VEC2;
            4'h3: vec_of = VEC3;
            4'h4: vec_of = VEC4;
            4'h5: vec_of = VEC5;
            4'h6: vec_of = VEC6;
            default: vec_of = VEC7;
        endcase
    endfunction

    // equal or higher level in service blocks the call
    // only on the last machine cycle of the instruction
    // and control write or return defers the call
    wire take = mc_tick_ff && found && last_cycle && !ctrl_write && !reti_exec
        && !blocked_by(in_service_ff, win_level);

    // Highest in-service bit ends on interrupt return
    wire [3:0] top_svc = in_service_ff[3] ? 4'h8 : in_service_ff[2] ? 4'h4 :
        in_service_ff[1] ? 4'h2 : in_service_ff[0] ? 4'h1 : 4'h0;
    wire [7:0] clr_mask = 8'h0F;

    // decision uses only flags sampled this cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_call_ff <= 1'b0;
            vector_addr_ff <= 16'h0000;
            clear_src_ff <= 8'h00;
            in_service_ff <= 4'h0;
        end else begin
            vector_call_ff <= take;
            // core pushes counter and loads this vector
            if (take)
                vector_addr_ff <= vec_of(win_idx);
            // timer 0, timer 1 and edge flags cleared; others kept
            clear_src_ff <= take ? ((8'h01 << win_idx) & clr_mask
                & ~{5'h00, !ext_mode_ff[1], 2'h0} & ~{7'h00, !ext_mode_ff[0]}) : 8'h00;
            // return ends level; plain return does not
            if (take)
                in_service_ff <= in_service_ff | (4'h1 << win_level);
            else if (mc_tick_ff && reti_exec && !ret_exec)
                in_service_ff <= in_service_ff & ~top_svc;
        end
    end

    // APB register access, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_reg <= 8'h00;
            priority_low_reg <= 8'h00;
            priority_high_reg <= 8'h00;
            extended_irq_control_reg <= 8'h00;
            ext_mode_ff <= 2'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup && paddr > `ADDR_SRC_FLAGS;
            if (apb_setup) begin
                if (paddr == `ADDR_IRQ_ENABLE) prdata_ff <= {24'h0, irq_enable_reg};
                else if (paddr == `ADDR_PRIO_LOW) prdata_ff <= {24'h0, priority_low_reg};
                else if (paddr == `ADDR_PRIO_HIGH) prdata_ff <= {24'h0, priority_high_reg};
                else if (paddr == `ADDR_XCTRL) prdata_ff <= {24'h0, extended_irq_control_reg};
                else if (paddr == `ADDR_EXT_MODE) prdata_ff <= {30'h0, ext_mode_ff};
                else if (paddr == `ADDR_STATUS) prdata_ff <= {28'h0, in_service_ff};
                else if (paddr == `ADDR_VECTOR) prdata_ff <= {16'h0, vector_addr_ff};
                else if (paddr == `ADDR_SRC_FLAGS) prdata_ff <= {24'h0, ext_request_flag};
                else prdata_ff <= 32'h0000_0000;
            end
            if (apb_wr) begin
                if (paddr == `ADDR_IRQ_ENABLE) irq_enable_reg <= pwdata[7:0];
                else if (paddr == `ADDR_PRIO_LOW) priority_low_reg <= pwdata[7:0];
                else if (paddr == `ADDR_PRIO_HIGH) priority_high_reg <= pwdata[7:0];
                else if (paddr == `ADDR_XCTRL) extended_irq_control_reg <= pwdata[7:0];
                else if (paddr == `ADDR_EXT_MODE) ext_mode_ff <= pwdata[1:0];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign vector_call = vector_call_ff;
    assign vector_addr = vector_addr_ff;
    assign clear_src = clear_src_ff;
    assign in_service = in_service_ff;

    // call only follows a last-cycle tick
    call_on_last_a: assert property (@(posedge pclk) disable iff (!presetn)
        vector_call |-> $past(last_cycle) && $past(mc_tick_ff))
        else $error("vector call outside last machine cycle");
    // no call after control write or return
    call_deferred_a: assert property (@(posedge pclk) disable iff (!presetn)
        vector_call |-> !$past(ctrl_write) && !$past(reti_exec))
        else $error("vector call after control write");
    // blocked when level already in service
    level_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        vector_call |-> (in_service & ~$past(in_service)) != 4'h0)
        else $error("call without new service level");
    // global enable off means no call
    global_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        !irq_enable_reg[`GLOBAL_EN_BIT] && !$past(irq_enable_reg[`GLOBAL_EN_BIT]) |-> !vector_call)
        else $error("call with global enable off");
    // serial and timer 2 never cleared
    keep_sw_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        clear_src[7:4] == 4'h0)
        else $error("hardware cleared a software flag");
    // clear pulse pairs with the call
    clear_pairs_a: assert property (@(posedge pclk) disable iff (!presetn)
        clear_src != 8'h00 |-> vector_call)
        else $error("flag clear without vector call");
    ret_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
        ret_exec && !reti_exec && mc_tick_ff |=> in_service >= $past(in_service))
        else $error("plain return changed in-service");
    // level mode of pin a never cleared by hardware
    level_noclr_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_mode_ff[0] && !$past(ext_mode_ff[0]) |-> !clear_src[`SRC_EXT_A])
        else $error("level flag cleared");
    // level mode of pin b never cleared
    level_noclr_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_mode_ff[1] && !$past(ext_mode_ff[1]) |-> !clear_src[`SRC_EXT_B])
        else $error("level flag of pin b cleared");
    // Clear pulse for pin a, then its edge flag drops
    sequence edge_cleared_s;
        clear_src == 8'h01 ##1 !edge_flag_a_ff;
    endsequence
    // edge-mode call of pin a clears its edge flag
    edge_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && win_idx == 4'h0 && ext_mode_ff[0] |=> edge_cleared_s)
        else $error("edge flag not cleared on call");
    // timer 0 or timer 1 call clears that timer's flag
    timer_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && (win_idx == 4'h1 || win_idx == 4'h3)
        |=> clear_src == (8'h01 << $past(win_idx)))
        else $error("timer flag not cleared on call");
    // interrupt return ends the top level
    reti_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        mc_tick_ff && reti_exec && !ret_exec |=> (in_service & $past(top_svc)) == 4'h0)
        else $error("interrupt return kept its level");
    // winner is enabled per source and globally
    enable_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        found |-> irq_enable_reg[win_idx[2:0]] && irq_enable_reg[`GLOBAL_EN_BIT])
        else $error("winner not enabled");
    // winner level from its two priority bits
    win_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        found |-> win_level == {prio_high_all[win_idx[2:0]], prio_low_all[win_idx[2:0]]})
        else $error("winner level mismatch");
    // Ready lasts a single access cycle
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");
endmodule

/* File: hdl/irq_vec_defines.svh */
// Constants of the priority interrupt vectoring unit
`ifndef IRQ_VEC_DEFINES_SVH
`define IRQ_VEC_DEFINES_SVH
`define NUM_SRC 8
`define MC_CLOCKS 12
`define MC_CNT_W 4
`define MC_LAST 4'hB
`define ADDR_IRQ_ENABLE 12'h000
`define ADDR_PRIO_LOW 12'h004
`define ADDR_PRIO_HIGH 12'h008
`define ADDR_XCTRL 12'h00C
`define ADDR_EXT_MODE 12'h010
`define ADDR_STATUS 12'h014
`define ADDR_VECTOR 12'h018
`define ADDR_SRC_FLAGS 12'h01C
`define GLOBAL_EN_BIT 7
`define SRC_EXT_A 0
`define SRC_TMR0 1
`define SRC_EXT_B 2
`define SRC_TMR1 3
`define SRC_SERIAL 4
`define SRC_TMR2 5
`define XCTRL_PRIO_A_BIT 3
`define XCTRL_PRIO_B_BIT 7
`endif

/* File: hdl/irq_vec_pkg.sv */
// Types of the priority interrupt vectoring unit
package irq_vec_pkg;
    typedef logic [1:0] level_type;
    typedef logic [15:0] vector_type;
    typedef logic [3:0] idx_type;
endpackage

/* File: hdl/level_resolver.sv */
// Combinational priority resolver over all pending sources
`timescale 1ns/1ps
module level_resolver (
    input wire logic [7:0] pend,
    input wire logic [7:0] prio_low,
    input wire logic [7:0] prio_high,
    output logic found,
    output irq_vec_pkg::idx_type win_idx,
    output irq_vec_pkg::level_type win_level
);
    import irq_vec_pkg::*;

    // Highest level wins; among equals the lower index wins
    always_comb begin
        found = 1'b0;
        win_idx = 4'h0;
        win_level = 2'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pend[i] && (!found || {prio_high[i], prio_low[i]} >= win_level)) begin
                found = 1'b1;
                win_idx = idx_type'(i);
                win_level = {prio_high[i], prio_low[i]};
            end
        end
    end
endmodule

/* File: verification/periph_model.sv */
// Timer flag model on the far side of the vectoring unit
`timescale 1ns/1ps
module periph_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_t0,
    input wire logic set_t1,
    input wire logic [7:0] clear_src,
    output logic tf0_ff,
    output logic tf1_ff
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tf0_ff <= 1'b0;
            tf1_ff <= 1'b0;
        end else begin
            tf0_ff <= set_t0 | (tf0_ff & !clear_src[1]);
            tf1_ff <= set_t1 | (tf1_ff & !clear_src[3]);
        end
    end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench of the priority interrupt vectoring unit
`timescale 1ns/1ps
module testbench;
    import irq_vec_pkg::*;
    localparam vector_type V0 = 16'h0100;
    localparam vector_type V1 = 16'h0210;
    localparam vector_type V2 = 16'h0320;
    localparam vector_type V3 = 16'h0430;
    localparam vector_type V4 = 16'h0540;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, slv, pin_a = 1'b1, pin_b = 1'b1, set_t0 = 1'b0, set_t1 = 1'b0;
    logic tf0, tf1, last_cycle = 1'b0, ctrl_write = 1'b0, reti_exec = 1'b0, ret_exec = 1'b0;
    logic [3:0] other_req = 4'h0, in_service;
    logic vector_call;
    vector_type vector_addr;
    logic [7:0] clear_src;
    logic [23:0] expq[$];
    int err_count = 0, checks = 0, tmo = 0;
    integer seed = 32'hD0D9E5A2;

    always #2.5 pclk = ~pclk;

    priority_interrupt_vectoring_unit #(.VEC0(V0), .VEC1(V1), .VEC2(V2), .VEC3(V3),
        .VEC4(V4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_request_pin_a(pin_a), .ext_request_pin_b(pin_b),
        .timer_zero_overflow_flag(tf0), .timer_one_overflow_flag(tf1),
        .other_req(other_req), .last_cycle(last_cycle), .ctrl_write(ctrl_write),
        .reti_exec(reti_exec), .ret_exec(ret_exec), .vector_call(vector_call),
        .vector_addr(vector_addr), .clear_src(clear_src), .in_service(in_service));
    periph_model u_periph (.pclk(pclk), .presetn(presetn), .set_t0(set_t0),
        .set_t1(set_t1), .clear_src(clear_src), .tf0_ff(tf0), .tf1_ff(tf1));

    task automatic fail(input string m);
        err_count++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) fail($sformatf("got %h exp %h", g, e));
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    task automatic expect_call(input vector_type v, input logic [7:0] c);
        expq.push_back({v, c});
        for (int i = 0; i < 60 && expq.size() != 0; i++) @(posedge pclk);
        if (expq.size() != 0) fail("no vector call");
        expq.delete();
    endtask
    // Holds a return for more than one machine cycle
    task automatic core(input logic r);
        reti_exec <= r;
        ret_exec <= !r;
        cyc(13);
        reti_exec <= 1'b0;
        ret_exec <= 1'b0;
        cyc(1);
    endtask
    task automatic stop_test;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Each call is matched against the oldest expected vector and clear mask
    always @(posedge pclk) begin
        if (vector_call === 1'b1) begin
            if (expq.size() == 0) fail("unexpected vector call");
            else chk({8'h0, vector_addr, clear_src}, {8'h0, expq.pop_front()});
        end
        tmo <= tmo + 1;
        if (tmo == 20000) begin
            fail("timeout");
            stop_test();
        end
    end

    initial begin
        cyc(2);
        presetn <= 1'b1;
        rd(12'h000, 32'h0);
        rv = $random(seed);
        apb(1'b1, 12'h000, {rv[31:8], 8'h82});
        rd(12'h000, 32'h82);
        rd(12'h020, 32'h0);
        chk({31'h0, slv}, 32'h1);
        $display("test registers done");
        last_cycle <= 1'b1;
        set_t0 <= 1'b1;
        cyc(1);
        set_t0 <= 1'b0;
        expect_call(V1, 8'h02);
        chk({28'h0, in_service}, 32'h1);
        apb(1'b1, 12'h000, 32'h8A);
        set_t1 <= 1'b1;
        cyc(1);
        set_t1 <= 1'b0;
        cyc(30);
        core(1'b1);
        expect_call(V3, 8'h08);
        core(1'b1);
        chk({28'h0, in_service}, 32'h0);
        $display("test timers done");
        apb(1'b1, 12'h000, 32'h90);
        last_cycle <= 1'b0;
        other_req <= 4'h1;
        cyc(30);
        other_req <= 4'h0;
        cyc(1);
        last_cycle <= 1'b1;
        cyc(30);
        other_req <= 4'h1;
        ctrl_write <= 1'b1;
        cyc(30);
        apb(1'b1, 12'h000, 32'h10);
        ctrl_write <= 1'b0;
        cyc(30);
        $display("test suppression done");
        apb(1'b1, 12'h004, 32'h10);
        apb(1'b1, 12'h008, 32'h10);
        set_t0 <= 1'b1;
        cyc(1);
        set_t0 <= 1'b0;
        apb(1'b1, 12'h000, 32'h92);
        expect_call(V4, 8'h00);
        chk({28'h0, in_service}, 32'h8);
        rd(12'h018, {16'h0, V4});
        rd(12'h014, 32'h8);
        other_req <= 4'h0;
        core(1'b0);
        chk({28'h0, in_service}, 32'h8);
        core(1'b1);
        expect_call(V1, 8'h02);
        core(1'b1);
        $display("test priority done");
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h000, 32'h85);
        // pin held low beyond a machine cycle
        pin_a <= 1'b0;
        expect_call(V0, 8'h01);
        cyc(13);
        pin_a <= 1'b1;
        core(1'b1);
        pin_b <= 1'b0;
        expect_call(V2, 8'h00);
        core(1'b1);
        expect_call(V2, 8'h00);
        pin_b <= 1'b1;
        core(1'b1);
        $display("test external pins done");
        stop_test();
    end
endmodule
